// ---- bench/ofs_checker.sv ----
// port checks for the output clock frequency select block
// assumes it is bound onto ofs_top and sees only that module's ports
module ofs_checker (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic [6:0] regAddr,
   input wire logic regWrEn,
   input wire logic [7:0] regWrData,
   input wire logic regRdEn,
   input wire logic regRdValid,
   input wire ofs_pkg::ofs_src_t [6:0] outSrc,
   input wire logic [6:0][6:0] outDiv,
   input wire ofs_pkg::ofs_aux_mode_t auxMode,
   input wire logic auxFromMain,
   input wire logic [18:0] auxApllKhz,
   input wire logic [18:0] auxFwdKhz
);
   import ofs_pkg::*;
   // ----------------------------------------------------------------
   // write decode
   // ----------------------------------------------------------------
   logic wr60, wr61, wr62, wr63, wr64, wr65;
   assign wr60 = regWrEn && regAddr == OFS_REG_OUT12;
   assign wr61 = regWrEn && regAddr == OFS_REG_OUT34;
   assign wr62 = regWrEn && regAddr == OFS_REG_OUT56;
   assign wr63 = regWrEn && regAddr == OFS_REG_OUT7;
   assign wr64 = regWrEn && regAddr == OFS_REG_AUX_CTRL;
   assign wr65 = regWrEn && regAddr == OFS_REG_MAIN_CTRL;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);
   // ----------------------------------------------------------------
   // properties: outputs follow a write two edges later
   // ----------------------------------------------------------------
   property p_off;
      wr60 && regWrData[3:0] == 4'h0 |-> ##2
         outSrc[0] == SRC_OFF && outDiv[0] == OFS_DIV_NONE;
   endproperty
   a_off: assert property (p_off)
      else $error("output one not off after code zero");
   property p_aux64;
      wr60 && regWrData[7:4] == 4'hb |-> ##2
         outSrc[1] == SRC_AUX && outDiv[1] == OFS_DIV_64;
   endproperty
   a_aux64: assert property (p_aux64)
      else $error("output two not aux over 64");
   property p_half4;
      wr61 && regWrData[7:4] == 4'hb |-> ##2
         outSrc[3] == SRC_AUX && outDiv[3] == OFS_DIV_2;
   endproperty
   a_half4: assert property (p_half4)
      else $error("output four not aux over 2");
   property p_one6;
      wr62 && regWrData[7:4] == 4'h5 |-> ##2
         outSrc[5] == SRC_MAIN && outDiv[5] == OFS_DIV_1;
   endproperty
   a_one6: assert property (p_one6)
      else $error("output six not undivided main");
   property p_half7;
      wr63 && regWrData[3:0] == 4'h4 |-> ##2
         outSrc[6] == SRC_MAIN && outDiv[6] == OFS_DIV_2;
   endproperty
   a_half7: assert property (p_half7)
      else $error("output seven not main over 2");
   // a later write to the enable bit cannot reach the outputs this soon
   property p_auxdpll;
      wr64 |-> ##2 auxFromMain ||
         auxMode == {1'b0, $past(regWrData[2:0], 2)};
   endproperty
   a_auxdpll: assert property (p_auxdpll)
      else $error("aux mode does not follow aux code");
   property p_m2a;
      wr65 && regWrData[6] |-> ##2 auxFromMain &&
         auxFwdKhz == OFS_KHZ_ZERO &&
         auxMode == {2'b10, $past(regWrData[5:4], 2)};
   endproperty
   a_m2a: assert property (p_m2a)
      else $error("main-fed aux mode wrong");
   property p_norm;
      !auxFromMain && auxMode == AUX_NORMAL |->
         auxFwdKhz == OFS_KHZ_77760 && auxApllKhz == OFS_KHZ_311040;
   endproperty
   a_norm: assert property (p_norm)
      else $error("normal aux mode frequencies wrong");
   c_m2a: cover property (wr65 && regWrData[6]);
   c_exc: cover property (wr61 && regWrData[7:4] == 4'hb);
   c_rd: cover property (regRdEn ##1 regRdValid);
endmodule

bind ofs_top ofs_checker i_ofs_checker (
   .sys_clk(sys_clk), .rst(rst), .regAddr(regAddr), .regWrEn(regWrEn),
   .regWrData(regWrData), .regRdEn(regRdEn), .regRdValid(regRdValid),
   .outSrc(outSrc), .outDiv(outDiv), .auxMode(auxMode),
   .auxFromMain(auxFromMain), .auxApllKhz(auxApllKhz),
   .auxFwdKhz(auxFwdKhz)
);

// ---- bench/testbench.sv ----
// self-checking bench for the output clock frequency select block
// assumes ofs_pkg, ofs_top and the bound checker are compiled first
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   import ofs_pkg::*;
   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   logic [6:0] regAddr = 7'h00;
   logic regWrEn = 1'b0;
   logic [7:0] regWrData = 8'h00;
   logic regRdEn = 1'b0;
   logic [7:0] regRdData;
   logic regRdValid, auxFromMain, auxSquelch, mainModeBad;
   ofs_src_t [6:0] outSrc;
   logic [6:0][6:0] outDiv;
   ofs_aux_mode_t auxMode;
   logic [18:0] auxApllKhz, auxFwdKhz, mainApllKhz;
   logic [7:0] regs [6];
   integer seed = 53;
   int failCount = 0;
   int nCompared = 0;
   always #10 sys_clk = ~sys_clk;
   ofs_top i_ofs_top (.sys_clk(sys_clk), .rst(rst), .regAddr(regAddr),
      .regWrEn(regWrEn), .regWrData(regWrData), .regRdEn(regRdEn),
      .regRdData(regRdData), .regRdValid(regRdValid), .outSrc(outSrc),
      .outDiv(outDiv), .auxMode(auxMode), .auxFromMain(auxFromMain),
      .auxSquelch(auxSquelch), .auxApllKhz(auxApllKhz),
      .auxFwdKhz(auxFwdKhz), .mainApllKhz(mainApllKhz),
      .mainModeBad(mainModeBad));
   // ----------------------------------------------------------------
   // expectations from the shadow copy of the registers
   // ----------------------------------------------------------------
   function automatic logic [18:0] apll(logic [2:0] c);
      case (c)
         3'h2: apll = OFS_KHZ_98304;
         3'h3: apll = OFS_KHZ_131072;
         3'h4: apll = OFS_KHZ_148224;
         3'h5: apll = OFS_KHZ_98816;
         3'h6: apll = OFS_KHZ_274944;
         3'h7: apll = OFS_KHZ_178944;
         default: apll = OFS_KHZ_311040;
      endcase
   endfunction
   function automatic logic [9:0] expOut(int n, logic [3:0] c);
      case (c)
         4'h0: expOut = {SRC_OFF, OFS_DIV_NONE};
         4'h1: expOut = {SRC_2K, OFS_DIV_NONE};
         4'h2: expOut = {SRC_8K, OFS_DIV_NONE};
         4'h3: expOut = n == 5 ? {SRC_MAIN, OFS_DIV_2} :
            {SRC_DIG2, OFS_DIV_NONE};
         4'h4: expOut = n == 6 ? {SRC_MAIN, OFS_DIV_2} :
            {SRC_DIG1, OFS_DIV_NONE};
         4'h5: expOut = n == 5 ? {SRC_MAIN, OFS_DIV_1} :
            {SRC_MAIN, OFS_DIV_48};
         4'h6: expOut = {SRC_MAIN, OFS_DIV_16};
         4'h7: expOut = {SRC_MAIN, OFS_DIV_12};
         4'h8: expOut = {SRC_MAIN, OFS_DIV_8};
         4'h9: expOut = {SRC_MAIN, OFS_DIV_6};
         4'ha: expOut = {SRC_MAIN, OFS_DIV_4};
         4'hb: expOut = (n == 3 || n == 4) ? {SRC_AUX, OFS_DIV_2} :
            {SRC_AUX, OFS_DIV_64};
         4'hc: expOut = {SRC_AUX, OFS_DIV_48};
         4'hd: expOut = {SRC_AUX, OFS_DIV_16};
         4'he: expOut = {SRC_AUX, OFS_DIV_8};
         default: expOut = {SRC_AUX, OFS_DIV_4};
      endcase
   endfunction
   // the forward synth runs at a quarter of the aux apll, and at zero when the aux is fed from main
   function automatic logic [133:0] expState();
      logic [20:0] s;
      logic [48:0] d;
      logic [9:0] o;
      logic [3:0] m;
      logic [18:0] a;
      logic f;
      for (int n = 0; n < 7; n++) begin
         o = expOut(n, n[0] ? regs[n / 2][7:4] : regs[n / 2][3:0]);
         s[n * 3 +: 3] = o[9:7];
         d[n * 7 +: 7] = o[6:0];
      end
      f = regs[5][6];
      m = f ? {2'b10, regs[5][5:4]} : {1'b0, regs[4][2:0]};
      a = f ? apll({1'b0, regs[5][5:4]} + 3'h2) : apll(regs[4][2:0]);
      expState = {s, d, m, f, m == 4'h0, a, f ? OFS_KHZ_ZERO : a >> 2,
         regs[5][2:1] == 2'b11 ? OFS_KHZ_ZERO : apll(regs[5][2:0]),
         regs[5][2:1] == 2'b11};
   endfunction
   // ----------------------------------------------------------------
   // compares, bus tasks and closing
   // ----------------------------------------------------------------
   task automatic cmpState();
      logic [133:0] g;
      g = {outSrc, outDiv, auxMode, auxFromMain, auxSquelch, auxApllKhz,
         auxFwdKhz, mainApllKhz, mainModeBad};
      nCompared++;
      if (g !== expState()) begin
         failCount++;
         $display("wrong value at %0t: got %h expected %h", $time, g,
            expState());
      end
   endtask
   task automatic cmpReg(logic [8:0] g, logic [8:0] e);
      nCompared++;
      if (g !== e) begin
         failCount++;
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   // write strobe stays up so back-to-back writes never drop it between them
   task automatic wr(logic [6:0] a, logic [7:0] d);
      regAddr <= a;
      regWrData <= d;
      regWrEn <= 1'b1;
      @(posedge sys_clk);
      if (a >= 7'h60 && a <= 7'h65)
         regs[a - 7'h60] = d;
   endtask
   task automatic settle();
      regWrEn <= 1'b0;
      @(posedge sys_clk);
      #1;
      cmpState();
      // hand back on an edge so the next task drives at the edge
      @(posedge sys_clk);
   endtask
   task automatic rd(logic [6:0] a);
      logic [7:0] e;
      e = (a >= 7'h60 && a <= 7'h65) ? regs[a - 7'h60] : 8'h00;
      regAddr <= a;
      regWrEn <= 1'b0;
      regRdEn <= 1'b1;
      @(posedge sys_clk);
      regRdEn <= 1'b0;
      // the valid pulse stands only until the next edge
      #1;
      cmpReg({regRdValid, regRdData}, {1'b1, e});
      @(posedge sys_clk);
   endtask
   task automatic testDone();
      if (failCount == 0 && nCompared > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   initial begin
      foreach (regs[i]) regs[i] = 8'h00;
      repeat (2) @(posedge sys_clk);
      rst <= 1'b0;
      settle();
      for (int i = 0; i < 6; i++) rd(7'h60 + i[6:0]);
      for (int c = 0; c < 16; c++) begin
         wr(OFS_REG_OUT12, {c[3:0], ~c[3:0]});
         wr(OFS_REG_OUT34, {c[3:0], c[3:0]});
         wr(OFS_REG_OUT56, {c[3:0], c[3:0]});
         wr(OFS_REG_OUT7, {~c[3:0], c[3:0]});
         settle();
      end
      for (int c = 0; c < 8; c++) begin
         wr(OFS_REG_AUX_CTRL, {5'($random(seed)), c[2:0]});
         wr(OFS_REG_MAIN_CTRL, {2'b00, 2'($random(seed)), 1'b0, c[2:0]});
         settle();
      end
      for (int c = 0; c < 4; c++) begin
         wr(OFS_REG_MAIN_CTRL, {2'b01, c[1:0], 1'b0, 3'($random(seed))});
         wr(OFS_REG_AUX_CTRL, 8'($random(seed)));
         settle();
      end
      repeat (40) begin
         wr(7'h5f + 7'($random(seed) & 7), 8'($random(seed)));
         rd(regAddr);
         settle();
      end
      rst <= 1'b1;
      repeat (2) @(posedge sys_clk);
      rst <= 1'b0;
      foreach (regs[i]) regs[i] = 8'h00;
      settle();
      testDone();
   end
   initial begin
      repeat (5000) @(posedge sys_clk);
      failCount++;
      testDone();
   end
endmodule

// ---- verilog/ofs_out_decode.sv ----
// one general output's select-code decoder with registered result
// assumes the code comes straight from a select register field
module ofs_out_decode #(
   parameter int OUT_NUM = 1
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic [3:0] selCode,
   output ofs_pkg::ofs_src_t srcSel_q,
   output logic [ofs_pkg::OFS_DIV_W-1:0] divSel_q
);
   import ofs_pkg::*;

   ofs_src_t srcSel_d;
   logic [OFS_DIV_W-1:0] divSel_d;

   // -----------------------------------------------------------------
   // code decode
   // -----------------------------------------------------------------
   always_comb begin
      srcSel_d = SRC_OFF;
      divSel_d = OFS_DIV_NONE;
      case (selCode)
         4'h0: srcSel_d = SRC_OFF;
         4'h1: srcSel_d = SRC_2K;
         4'h2: srcSel_d = SRC_8K;
         4'h3: begin
            if (OUT_NUM == 6) begin
               srcSel_d = SRC_MAIN;
               divSel_d = OFS_DIV_2;
            end else begin
               srcSel_d = SRC_DIG2;
            end
         end
         4'h4: begin
            if (OUT_NUM == 7) begin
               srcSel_d = SRC_MAIN;
               divSel_d = OFS_DIV_2;
            end else begin
               srcSel_d = SRC_DIG1;
            end
         end
         4'h5: begin
            srcSel_d = SRC_MAIN;
            divSel_d = (OUT_NUM == 6) ? OFS_DIV_1 : OFS_DIV_48;
         end
         4'h6: begin
            srcSel_d = SRC_MAIN;
            divSel_d = OFS_DIV_16;
         end
         4'h7: begin
            srcSel_d = SRC_MAIN;
            divSel_d = OFS_DIV_12;
         end
         4'h8: begin
            srcSel_d = SRC_MAIN;
            divSel_d = OFS_DIV_8;
         end
         4'h9: begin
            srcSel_d = SRC_MAIN;
            divSel_d = OFS_DIV_6;
         end
         4'ha: begin
            srcSel_d = SRC_MAIN;
            divSel_d = OFS_DIV_4;
         end
         4'hb: begin
            srcSel_d = SRC_AUX;
            // outputs four and five reach the fast aux tap instead
            divSel_d = (OUT_NUM == 4 || OUT_NUM == 5) ? OFS_DIV_2
                                                      : OFS_DIV_64;
         end
         4'hc: begin
            srcSel_d = SRC_AUX;
            divSel_d = OFS_DIV_48;
         end
         4'hd: begin
            srcSel_d = SRC_AUX;
            divSel_d = OFS_DIV_16;
         end
         4'he: begin
            srcSel_d = SRC_AUX;
            divSel_d = OFS_DIV_8;
         end
         4'hf: begin
            srcSel_d = SRC_AUX;
            divSel_d = OFS_DIV_4;
         end
         default: srcSel_d = SRC_OFF;
      endcase
   end

   // -----------------------------------------------------------------
   // output flops
   // -----------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         srcSel_q <= SRC_OFF;
         divSel_q <= OFS_DIV_NONE;
      end else begin
         srcSel_q <= srcSel_d;
         divSel_q <= divSel_d;
      end
   end

endmodule

// ---- verilog/ofs_pkg.sv ----
// constants, types and tables for the output clock frequency select block
// assumes one clock domain and a byte-wide register port with 7-bit address
//
// Function
// - aux dpll field sets aux mode when unlinked
// - main-to-aux enable: 2-bit main-fed mode select
// - codes 0000..1010: off, 2k, 8k, digital, main
// - codes 1011..1111: aux apll divided 64..4 (divided 2 at 1011 for outputs four and five)
// - each output owns one 4-bit register field
package ofs_pkg;

   // -----------------------------------------------------------------
   // register map
   // -----------------------------------------------------------------
   localparam int OFS_ADDR_W = 7;
   localparam int OFS_DATA_W = 8;
   localparam logic [6:0] OFS_REG_OUT12 = 7'h60;
   localparam logic [6:0] OFS_REG_OUT34 = 7'h61;
   localparam logic [6:0] OFS_REG_OUT56 = 7'h62;
   localparam logic [6:0] OFS_REG_OUT7 = 7'h63;
   localparam logic [6:0] OFS_REG_AUX_CTRL = 7'h64;
   localparam logic [6:0] OFS_REG_MAIN_CTRL = 7'h65;
   localparam logic [7:0] OFS_RST_VAL = 8'h00;

   // -----------------------------------------------------------------
   // field positions
   // -----------------------------------------------------------------
   localparam int OFS_SEL_LO_LSB = 0;
   localparam int OFS_SEL_HI_LSB = 4;
   localparam int OFS_SEL_W = 4;
   localparam int OFS_DPLL_LSB = 0;
   localparam int OFS_DPLL_W = 3;
   localparam int OFS_M2A_SEL_LSB = 4;
   localparam int OFS_M2A_SEL_W = 2;
   localparam int OFS_M2A_EN_BIT = 6;
   localparam int OFS_NUM_OUT = 7;

   // -----------------------------------------------------------------
   // dividers and frequencies (kHz)
   // -----------------------------------------------------------------
   localparam int OFS_DIV_W = 7;
   localparam logic [6:0] OFS_DIV_NONE = 7'h00;
   localparam logic [6:0] OFS_DIV_1 = 7'h01;
   localparam logic [6:0] OFS_DIV_2 = 7'h02;
   localparam logic [6:0] OFS_DIV_4 = 7'h04;
   localparam logic [6:0] OFS_DIV_6 = 7'h06;
   localparam logic [6:0] OFS_DIV_8 = 7'h08;
   localparam logic [6:0] OFS_DIV_12 = 7'h0c;
   localparam logic [6:0] OFS_DIV_16 = 7'h10;
   localparam logic [6:0] OFS_DIV_48 = 7'h30;
   localparam logic [6:0] OFS_DIV_64 = 7'h40;
   localparam int OFS_KHZ_W = 19;
   localparam logic [18:0] OFS_KHZ_311040 = 19'h4bf00;
   localparam logic [18:0] OFS_KHZ_98304 = 19'h18000;
   localparam logic [18:0] OFS_KHZ_131072 = 19'h20000;
   localparam logic [18:0] OFS_KHZ_148224 = 19'h24300;
   localparam logic [18:0] OFS_KHZ_98816 = 19'h18200;
   localparam logic [18:0] OFS_KHZ_274944 = 19'h43200;
   localparam logic [18:0] OFS_KHZ_178944 = 19'h2bb00;
   localparam logic [18:0] OFS_KHZ_77760 = 19'h12fc0;
   localparam logic [18:0] OFS_KHZ_24576 = 19'h06000;
   localparam logic [18:0] OFS_KHZ_32768 = 19'h08000;
   localparam logic [18:0] OFS_KHZ_37056 = 19'h090c0;
   localparam logic [18:0] OFS_KHZ_24704 = 19'h06080;
   localparam logic [18:0] OFS_KHZ_68736 = 19'h10c80;
   localparam logic [18:0] OFS_KHZ_44736 = 19'h0aec0;
   localparam logic [18:0] OFS_KHZ_ZERO = 19'h00000;

   // -----------------------------------------------------------------
   // types
   // -----------------------------------------------------------------
   typedef enum logic [2:0] {
      SRC_OFF, SRC_2K, SRC_8K, SRC_DIG2, SRC_DIG1, SRC_MAIN, SRC_AUX
   } ofs_src_t;

   typedef enum logic [3:0] {
      AUX_SQUELCH, AUX_NORMAL, AUX_12E1, AUX_16E1, AUX_24DS1, AUX_16DS1,
      AUX_E3, AUX_DS3, AUX_MAIN_12E1, AUX_MAIN_16E1, AUX_MAIN_24DS1,
      AUX_MAIN_16DS1
   } ofs_aux_mode_t;

   // aux apll frequency for a given aux mode
   function automatic logic [18:0] ofs_aux_apll_khz(ofs_aux_mode_t m);
      case (m)
         AUX_SQUELCH, AUX_NORMAL: ofs_aux_apll_khz = OFS_KHZ_311040;
         AUX_12E1, AUX_MAIN_12E1: ofs_aux_apll_khz = OFS_KHZ_98304;
         AUX_16E1, AUX_MAIN_16E1: ofs_aux_apll_khz = OFS_KHZ_131072;
         AUX_24DS1, AUX_MAIN_24DS1: ofs_aux_apll_khz = OFS_KHZ_148224;
         AUX_16DS1, AUX_MAIN_16DS1: ofs_aux_apll_khz = OFS_KHZ_98816;
         AUX_E3: ofs_aux_apll_khz = OFS_KHZ_274944;
         AUX_DS3: ofs_aux_apll_khz = OFS_KHZ_178944;
         default: ofs_aux_apll_khz = OFS_KHZ_ZERO;
      endcase
   endfunction

   // main apll frequency from the 3-bit main dpll field, zero if unusable
   function automatic logic [18:0] ofs_main_apll_khz(logic [2:0] c);
      case (c)
         3'h0, 3'h1: ofs_main_apll_khz = OFS_KHZ_311040;
         3'h2: ofs_main_apll_khz = OFS_KHZ_98304;
         3'h3: ofs_main_apll_khz = OFS_KHZ_131072;
         3'h4: ofs_main_apll_khz = OFS_KHZ_148224;
         3'h5: ofs_main_apll_khz = OFS_KHZ_98816;
         default: ofs_main_apll_khz = OFS_KHZ_ZERO;
      endcase
   endfunction

endpackage

// ---- verilog/ofs_top.sv ----
// output clock frequency select: select registers, aux mode decode and
// per-output source/divider selection for seven general outputs
// assumes a synchronous byte-wide register port from the processor side
module ofs_top (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic [ofs_pkg::OFS_ADDR_W-1:0] regAddr,
   input wire logic regWrEn,
   input wire logic [ofs_pkg::OFS_DATA_W-1:0] regWrData,
   input wire logic regRdEn,
   output logic [ofs_pkg::OFS_DATA_W-1:0] regRdData,
   output logic regRdValid,
   output ofs_pkg::ofs_src_t [ofs_pkg::OFS_NUM_OUT-1:0] outSrc,
   output logic [ofs_pkg::OFS_NUM_OUT-1:0][ofs_pkg::OFS_DIV_W-1:0] outDiv,
   output ofs_pkg::ofs_aux_mode_t auxMode,
   output logic auxFromMain,
   output logic auxSquelch,
   output logic [ofs_pkg::OFS_KHZ_W-1:0] auxApllKhz,
   output logic [ofs_pkg::OFS_KHZ_W-1:0] auxFwdKhz,
   output logic [ofs_pkg::OFS_KHZ_W-1:0] mainApllKhz,
   output logic mainModeBad
);
   import ofs_pkg::*;

   // -----------------------------------------------------------------
   // register file
   // -----------------------------------------------------------------
   logic [7:0] out12_q;
   logic [7:0] out34_q;
   logic [7:0] out56_q;
   logic [7:0] out7_q;
   logic [7:0] auxCtrl_q;
   logic [7:0] mainCtrl_q;

   wire hitOut12 = (regAddr == OFS_REG_OUT12);
   wire hitOut34 = (regAddr == OFS_REG_OUT34);
   wire hitOut56 = (regAddr == OFS_REG_OUT56);
   wire hitOut7 = (regAddr == OFS_REG_OUT7);
   wire hitAux = (regAddr == OFS_REG_AUX_CTRL);
   wire hitMain = (regAddr == OFS_REG_MAIN_CTRL);

   // -----------------------------------------------------------------
   // write strobes
   // -----------------------------------------------------------------
   // unmapped addresses raise no strobe, so such writes are dropped
   wire wrOut12 = regWrEn && hitOut12;
   wire wrOut34 = regWrEn && hitOut34;
   wire wrOut56 = regWrEn && hitOut56;
   wire wrOut7 = regWrEn && hitOut7;
   wire wrAux = regWrEn && hitAux;
   wire wrMain = regWrEn && hitMain;

   // all bits are stored as written, including fields owned elsewhere,
   // so software reads back exactly what it wrote
   always_ff @(posedge sys_clk) begin
      if (rst) out12_q <= OFS_RST_VAL;
      else if (wrOut12) out12_q <= regWrData;
   end

   always_ff @(posedge sys_clk) begin
      if (rst) out34_q <= OFS_RST_VAL;
      else if (wrOut34) out34_q <= regWrData;
   end

   always_ff @(posedge sys_clk) begin
      if (rst) out56_q <= OFS_RST_VAL;
      else if (wrOut56) out56_q <= regWrData;
   end

   always_ff @(posedge sys_clk) begin
      if (rst) out7_q <= OFS_RST_VAL;
      else if (wrOut7) out7_q <= regWrData;
   end

   always_ff @(posedge sys_clk) begin
      if (rst) auxCtrl_q <= OFS_RST_VAL;
      else if (wrAux) auxCtrl_q <= regWrData;
   end

   always_ff @(posedge sys_clk) begin
      if (rst) mainCtrl_q <= OFS_RST_VAL;
      else if (wrMain) mainCtrl_q <= regWrData;
   end

   // -----------------------------------------------------------------
   // read path
   // -----------------------------------------------------------------
   // unmapped addresses read as zero
   wire [7:0] rdMux =
      hitOut12 ? out12_q :
      hitOut34 ? out34_q :
      hitOut56 ? out56_q :
      hitOut7 ? out7_q :
      hitAux ? auxCtrl_q :
      hitMain ? mainCtrl_q : 8'h00;

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         regRdData <= 8'h00;
         regRdValid <= 1'b0;
      end else begin
         regRdValid <= regRdEn;
         if (regRdEn) regRdData <= rdMux;
      end
   end

   // -----------------------------------------------------------------
   // select fields per output
   // -----------------------------------------------------------------
   logic [OFS_NUM_OUT-1:0][OFS_SEL_W-1:0] selField;

   // low nibble is the odd output, high nibble the even one
   assign selField[0] = out12_q[OFS_SEL_LO_LSB +: OFS_SEL_W];
   assign selField[1] = out12_q[OFS_SEL_HI_LSB +: OFS_SEL_W];
   assign selField[2] = out34_q[OFS_SEL_LO_LSB +: OFS_SEL_W];
   assign selField[3] = out34_q[OFS_SEL_HI_LSB +: OFS_SEL_W];
   assign selField[4] = out56_q[OFS_SEL_LO_LSB +: OFS_SEL_W];
   assign selField[5] = out56_q[OFS_SEL_HI_LSB +: OFS_SEL_W];
   assign selField[6] = out7_q[OFS_SEL_LO_LSB +: OFS_SEL_W];

   genvar gi;
   generate
      for (gi = 0; gi < OFS_NUM_OUT; gi++) begin : g_out
         ofs_out_decode #(
            .OUT_NUM(gi + 1)
         ) u_dec (
            .sys_clk(sys_clk),
            .rst(rst),
            .selCode(selField[gi]),
            .srcSel_q(outSrc[gi]),
            .divSel_q(outDiv[gi])
         );
      end
   endgenerate

   // -----------------------------------------------------------------
   // aux path mode
   // -----------------------------------------------------------------
   wire m2aEn = mainCtrl_q[OFS_M2A_EN_BIT];
   wire [1:0] m2aSel = mainCtrl_q[OFS_M2A_SEL_LSB +: OFS_M2A_SEL_W];
   wire [2:0] auxCode = auxCtrl_q[OFS_DPLL_LSB +: OFS_DPLL_W];
   wire [2:0] mainCode = mainCtrl_q[OFS_DPLL_LSB +: OFS_DPLL_W];

   ofs_aux_mode_t auxMode_d;

   // with the main feed enabled the aux dpll code is don't-care
   always_comb begin
      auxMode_d = AUX_SQUELCH;
      if (m2aEn) begin
         case (m2aSel)
            2'h0: auxMode_d = AUX_MAIN_12E1;
            2'h1: auxMode_d = AUX_MAIN_16E1;
            2'h2: auxMode_d = AUX_MAIN_24DS1;
            2'h3: auxMode_d = AUX_MAIN_16DS1;
            default: auxMode_d = AUX_MAIN_12E1;
         endcase
      end else begin
         case (auxCode)
            3'h0: auxMode_d = AUX_SQUELCH;
            3'h1: auxMode_d = AUX_NORMAL;
            3'h2: auxMode_d = AUX_12E1;
            3'h3: auxMode_d = AUX_16E1;
            3'h4: auxMode_d = AUX_24DS1;
            3'h5: auxMode_d = AUX_16DS1;
            3'h6: auxMode_d = AUX_E3;
            3'h7: auxMode_d = AUX_DS3;
            default: auxMode_d = AUX_SQUELCH;
         endcase
      end
   end

   // forward synthesizer rate; none when the aux apll is fed from main
   logic [OFS_KHZ_W-1:0] auxFwd_d;

   always_comb begin
      auxFwd_d = OFS_KHZ_ZERO;
      case (auxMode_d)
         AUX_SQUELCH, AUX_NORMAL: auxFwd_d = OFS_KHZ_77760;
         AUX_12E1: auxFwd_d = OFS_KHZ_24576;
         AUX_16E1: auxFwd_d = OFS_KHZ_32768;
         AUX_24DS1: auxFwd_d = OFS_KHZ_37056;
         AUX_16DS1: auxFwd_d = OFS_KHZ_24704;
         AUX_E3: auxFwd_d = OFS_KHZ_68736;
         AUX_DS3: auxFwd_d = OFS_KHZ_44736;
         default: auxFwd_d = OFS_KHZ_ZERO;
      endcase
   end

   // codes 110 and 111 are not to be used: flag them and report no rate
   // rather than guess what the main apll would do
   wire mainBad_d = (mainCode == 3'h6) || (mainCode == 3'h7);
   wire [OFS_KHZ_W-1:0] mainApll_d = ofs_main_apll_khz(mainCode);
   wire [OFS_KHZ_W-1:0] auxApll_d = ofs_aux_apll_khz(auxMode_d);
   wire auxSquelch_d = (auxMode_d == AUX_SQUELCH);

   // -----------------------------------------------------------------
   // aux path outputs
   // -----------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         auxMode <= AUX_SQUELCH;
         auxFromMain <= 1'b0;
         auxSquelch <= 1'b1;
         auxApllKhz <= OFS_KHZ_311040;
         auxFwdKhz <= OFS_KHZ_77760;
      end else begin
         auxMode <= auxMode_d;
         auxFromMain <= m2aEn;
         auxSquelch <= auxSquelch_d;
         auxApllKhz <= auxApll_d;
         auxFwdKhz <= auxFwd_d;
      end
   end

   // -----------------------------------------------------------------
   // main path outputs
   // -----------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         mainApllKhz <= OFS_KHZ_311040;
         mainModeBad <= 1'b0;
      end else begin
         mainApllKhz <= mainApll_d;
         mainModeBad <= mainBad_d;
      end
   end

endmodule
